// File: hw/qdc_ctrl.sv
// command decode, frame handling and update control of the quad converter
//
// Behaviour
// [R1] a frame is 32 bits under low frame select; act on 32nd falling clock
// [R2] frame select rising before the 32nd edge discards the frame entirely
// [R3] command 1000: bit 1 sets chain enable, bit 0 internal reference
// [R4] power field 00 normal, 01 1k to ground, 10 100k, 11 three-state
// [R5] command 0100 applies power mode to channels selected in bits 3..0
// [R6] channel returning to normal reloads from input register if load low
// [R7] clear pin acts on its falling edge only, not on its level
// [R8] clear loads input and converter registers of all channels with clear code
// [R9] clear selection in bits 1..0; default gives 0 V
// [R10] clear selection 00 zero, 01 midscale, 10 full scale, 11 no operation
// [R11] command 0101 loads clear selection from the two low data bits
// [R12] clear mode ends on the 32nd edge of the next valid frame
// [R13] clear edge during a frame aborts that frame unapplied
// [R14] load strobe low: addressed converter register updates on the 32nd edge
// [R15] load strobe falling copies input registers into converter registers; the code skips channels whose mask bit is set
// [R16] command 0011 writes addressed input then updates all converter registers
// [R17] channel with mask bit set updates on new data regardless of strobe
// [R18] command 0110 loads the 4-bit mask from bits 3..0; resets to zero
// [R19] reset clears chain, reference, mask, clear selection; all channels normal
module qdc_ctrl (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic frame_sel_n,
   input wire logic serial_data_in,
   input wire logic load_strobe_n,
   input wire logic async_clear_n,
   output logic [qdc_pkg::NCH*qdc_pkg::CODE_W-1:0] conv_code,
   output logic [2*qdc_pkg::NCH-1:0] power_mode,
   output logic chain_enable,
   output logic vref_on,
   output logic clear_mode,
   output logic serial_data_out
);
   import qdc_pkg::*;

   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_s;
   logic [PIN_W-1:0] pin_rise;
   logic [PIN_W-1:0] pin_fall;
   logic sclk_fall;
   logic sclk_rise;
   logic frame_fell;
   logic frame_rose;
   logic din_s;
   logic load_low;
   logic load_fell;
   logic clear_fell;

   qdc_frame_t state_q;
   logic [CNT_W-1:0] cnt_q;
   logic [FRAME_BITS-1:0] shift_q;
   logic [FRAME_BITS-1:0] word;
   logic frame_open;
   logic exec;

   logic [3:0] cmd;
   logic [3:0] addr;
   logic [CODE_W-1:0] data;
   logic [1:0] pd_field;
   logic [3:0] sel_field;
   logic [1:0] clr_field;

   logic chain_q;
   logic vref_q;
   logic [2*NCH-1:0] pm_q;
   logic [NCH-1:0] mask_q;
   logic [1:0] clr_sel_q;
   logic clr_mode_q;
   logic sout_q;

   logic wr_cmd;
   logic [NCH-1:0] wr_en;
   logic [NCH-1:0] upd_en;
   logic [NCH-1:0] pwr_up;
   logic clr_evt;
   logic [CODE_W-1:0] clr_val;

   always_comb begin
      pin_raw = '0;
      pin_raw[PIN_SCLK] = sclk;
      pin_raw[PIN_FRAME] = frame_sel_n;
      pin_raw[PIN_DIN] = serial_data_in;
      pin_raw[PIN_LOAD] = load_strobe_n;
      pin_raw[PIN_CLR] = async_clear_n;
   end

   // every pin is asynchronous to clk, so all pass the same two stages
   qdc_sync u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin_async(pin_raw),
      .level_q(pin_s),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   assign sclk_fall = pin_fall[PIN_SCLK];
   assign sclk_rise = pin_rise[PIN_SCLK];
   assign frame_fell = pin_fall[PIN_FRAME];
   assign frame_rose = pin_rise[PIN_FRAME];
   assign din_s = pin_s[PIN_DIN];
   assign load_low = !pin_s[PIN_LOAD];
   assign load_fell = pin_fall[PIN_LOAD];
   // a held-low clear does nothing further; only the edge counts
   assign clear_fell = pin_fall[PIN_CLR]; // [R7]

   // data and clock share one synchroniser delay, so din is aligned to its edge
   assign word = {shift_q[FRAME_BITS-2:0], din_s};
   assign frame_open = (state_q == FR_SHIFT);
   assign exec = frame_open && sclk_fall && (cnt_q == FRAME_LAST) && !clear_fell; // [R1] [R13]

   assign cmd = word[CMD_HI:CMD_LO];
   assign addr = word[ADDR_HI:ADDR_LO];
   assign data = word[DATA_HI:DATA_LO];
   assign pd_field = word[PD_HI:PD_LO];
   assign sel_field = word[SEL_HI:SEL_LO];
   assign clr_field = word[CLRSEL_HI:CLRSEL_LO];

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q <= FR_IDLE;
      end else begin
         case (state_q)
            FR_IDLE: begin
               if (frame_fell) begin
                  state_q <= FR_SHIFT;
               end
            end
            FR_SHIFT: begin
               if (frame_rose) begin
                  state_q <= FR_IDLE; // [R2]
               end else if (clear_fell) begin
                  state_q <= FR_ABORT; // [R13]
               end else if (exec) begin
                  state_q <= FR_DONE; // [R1]
               end
            end
            FR_DONE, FR_ABORT: begin
               if (frame_rose) begin
                  state_q <= FR_IDLE;
               end
            end
            default: begin
               state_q <= FR_IDLE;
            end
         endcase
      end
   end

   // shifting goes on past 32 bits so a chained part sees the overflow
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_q <= '0;
         shift_q <= '0;
      end else if (state_q == FR_IDLE || frame_rose) begin
         cnt_q <= '0; // [R2]
         shift_q <= '0; // [R2]
      end else if (sclk_fall) begin
         shift_q <= word;
         if (cnt_q != FRAME_FULL) begin
            cnt_q <= cnt_q + CNT_ONE;
         end
      end
   end

   // overflow bits leave on the rising clock so they settle for the next falling one
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sout_q <= RST_FLAG;
      end else if (sclk_rise && state_q != FR_IDLE) begin
         sout_q <= chain_q & shift_q[FRAME_BITS-1];
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         chain_q <= RST_FLAG; // [R19]
         vref_q <= RST_FLAG; // [R19]
      end else if (exec && cmd == CMD_CHAIN_REF) begin
         chain_q <= word[CHAIN_BIT]; // [R3]
         vref_q <= word[VREF_BIT]; // [R3]
      end
   end

   // each channel keeps its own two-bit mode; encoding follows the power field
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pm_q <= RST_PM; // [R19]
      end else if (exec && cmd == CMD_POWER) begin
         for (int i = 0; i < NCH; i++) begin
            if (sel_field[i]) begin
               pm_q[2*i +: 2] <= pd_field; // [R4] [R5]
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         clr_sel_q <= RST_CLR_SEL; // [R9] [R19]
      end else if (exec && cmd == CMD_CLR_SEL) begin
         clr_sel_q <= clr_field; // [R11]
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mask_q <= RST_MASK; // [R18] [R19]
      end else if (exec && cmd == CMD_MASK) begin
         mask_q <= sel_field; // [R18]
      end
   end

   // exec never shares a cycle with a clear edge, so set and clear cannot collide
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         clr_mode_q <= RST_FLAG;
      end else if (clr_evt) begin
         clr_mode_q <= 1'b1;
      end else if (exec) begin
         clr_mode_q <= 1'b0; // [R12]
      end
   end

   assign clr_evt = clear_fell && (clr_sel_q != CLR_NOP); // [R8] [R10]
   assign clr_val = clear_code(clr_sel_q); // [R10]

   always_comb begin
      wr_cmd = exec && (cmd == CMD_WR_IN || cmd == CMD_WR_UPD_N || cmd == CMD_WR_UPD_ALL);
      wr_en = '0;
      upd_en = '0;
      pwr_up = '0;
      for (int i = 0; i < NCH; i++) begin
         wr_en[i] = wr_cmd && addr_hit(addr, i);
         pwr_up[i] = exec && cmd == CMD_POWER && sel_field[i] && pd_field == PM_NORMAL
            && pm_q[2*i +: 2] != PM_NORMAL;
         upd_en[i] = (wr_en[i] && (load_low || mask_q[i])) // [R14] [R17]
            || (exec && cmd == CMD_UPD_N && addr_hit(addr, i))
            || (wr_en[i] && cmd == CMD_WR_UPD_N)
            || (exec && cmd == CMD_WR_UPD_ALL) // [R16]
            || (load_fell && !mask_q[i]) // [R15]
            || (pwr_up[i] && load_low); // [R6]
      end
   end

   for (genvar g = 0; g < NCH; g++) begin : g_ch
      qdc_chan u_chan (
         .clk(clk),
         .reset_n(reset_n),
         .wr_en(wr_en[g]),
         .upd_en(upd_en[g]),
         .clr_en(clr_evt),
         .wr_data(data),
         .clr_data(clr_val),
         .conv_q(conv_code[g*CODE_W +: CODE_W])
      );
   end

   assign power_mode = pm_q;
   assign chain_enable = chain_q;
   assign vref_on = vref_q;
   assign clear_mode = clr_mode_q;
   assign serial_data_out = sout_q;

   property p_frame_exec;
      @(posedge clk) disable iff (!reset_n)
      (exec && !frame_rose) |=> (state_q == FR_DONE) && (cnt_q == FRAME_FULL);
   endproperty
   a_frame_exec: assert property (p_frame_exec) // [R1]
      else $error("frame did not complete on the last clock edge");

   property p_short_frame;
      @(posedge clk) disable iff (!reset_n)
      (frame_open && frame_rose && !exec) |=> (cnt_q == '0) && (state_q == FR_IDLE)
         && $stable(mask_q) && $stable(pm_q);
   endproperty
   a_short_frame: assert property (p_short_frame) // [R2]
      else $error("short frame was not discarded");

   property p_chain_ref;
      @(posedge clk) disable iff (!reset_n)
      (exec && cmd == CMD_CHAIN_REF) |=> (chain_q == $past(word[CHAIN_BIT]))
         && (vref_q == $past(word[VREF_BIT]));
   endproperty
   a_chain_ref: assert property (p_chain_ref) // [R3]
      else $error("chain or reference flag not taken from frame");

   property p_power_mode;
      @(posedge clk) disable iff (!reset_n)
      (exec && cmd == CMD_POWER && sel_field[0]) |=> (power_mode[1:0] == $past(pd_field));
   endproperty
   a_power_mode: assert property (p_power_mode) // [R5]
      else $error("selected channel did not take the power mode");

   property p_clear_load;
      @(posedge clk) disable iff (!reset_n)
      clr_evt |=> (conv_code[CODE_W-1:0] == $past(clr_val))
         && (conv_code[NCH*CODE_W-1 -: CODE_W] == $past(clr_val)) && clear_mode;
   endproperty
   a_clear_load: assert property (p_clear_load) // [R8]
      else $error("clear did not load the clear code");

   property p_clear_nop;
      @(posedge clk) disable iff (!reset_n)
      (clear_fell && clr_sel_q == CLR_NOP && upd_en == '0) |=> $stable(conv_code);
   endproperty
   a_clear_nop: assert property (p_clear_nop) // [R10]
      else $error("clear selection 11 changed an output");

   property p_clear_sel;
      @(posedge clk) disable iff (!reset_n)
      (exec && cmd == CMD_CLR_SEL) |=> (clr_sel_q == $past(clr_field));
   endproperty
   a_clear_sel: assert property (p_clear_sel) // [R11]
      else $error("clear selection not loaded");

   property p_clear_exit;
      @(posedge clk) disable iff (!reset_n)
      (clr_mode_q && exec) |=> !clear_mode;
   endproperty
   a_clear_exit: assert property (p_clear_exit) // [R12]
      else $error("clear mode kept after a valid frame");

   property p_clear_abort;
      @(posedge clk) disable iff (!reset_n)
      (frame_open && clear_fell && !frame_rose) |=> (!exec) [*8];
   endproperty
   a_clear_abort: assert property (p_clear_abort) // [R13]
      else $error("frame applied after a clear edge");

   property p_mask_update;
      @(posedge clk) disable iff (!reset_n)
      (wr_en[0] && mask_q[0]) |=> (conv_code[CODE_W-1:0] == $past(data));
   endproperty
   a_mask_update: assert property (p_mask_update) // [R17]
      else $error("masked channel did not update on new data");

   property p_mask_load;
      @(posedge clk) disable iff (!reset_n)
      (exec && cmd == CMD_MASK) |=> (mask_q == $past(sel_field));
   endproperty
   a_mask_load: assert property (p_mask_load) // [R18]
      else $error("load mask not taken from frame");
endmodule

// File: hw/qdc_pkg.sv
// shared constants, frame layout and helpers for the quad converter control
package qdc_pkg;
   localparam int FRAME_BITS = 32;
   localparam int CNT_W = 6;
   localparam logic [5:0] FRAME_LAST = 6'h1f;
   localparam logic [5:0] FRAME_FULL = 6'h20;
   localparam logic [5:0] CNT_ONE = 6'h01;
   localparam int NCH = 4;
   localparam int CODE_W = 16;
   localparam int PIN_W = 5;
   localparam int PIN_SCLK = 0;
   localparam int PIN_FRAME = 1;
   localparam int PIN_DIN = 2;
   localparam int PIN_LOAD = 3;
   localparam int PIN_CLR = 4;
   localparam logic [4:0] PIN_IDLE = 5'h1f;
   localparam int CMD_HI = 27;
   localparam int CMD_LO = 24;
   localparam int ADDR_HI = 23;
   localparam int ADDR_LO = 20;
   localparam int DATA_HI = 19;
   localparam int DATA_LO = 4;
   localparam int PD_HI = 9;
   localparam int PD_LO = 8;
   localparam int SEL_HI = 3;
   localparam int SEL_LO = 0;
   localparam int CHAIN_BIT = 1;
   localparam int VREF_BIT = 0;
   localparam int CLRSEL_HI = 1;
   localparam int CLRSEL_LO = 0;
   localparam logic [3:0] CMD_WR_IN = 4'h0;
   localparam logic [3:0] CMD_UPD_N = 4'h1;
   localparam logic [3:0] CMD_WR_UPD_N = 4'h2;
   localparam logic [3:0] CMD_WR_UPD_ALL = 4'h3;
   localparam logic [3:0] CMD_POWER = 4'h4;
   localparam logic [3:0] CMD_CLR_SEL = 4'h5;
   localparam logic [3:0] CMD_MASK = 4'h6;
   localparam logic [3:0] CMD_CHAIN_REF = 4'h8;
   localparam logic [3:0] ADDR_ALL = 4'hf;
   localparam logic [1:0] PM_NORMAL = 2'h0;
   localparam logic [1:0] PM_1K = 2'h1;
   localparam logic [1:0] PM_100K = 2'h2;
   localparam logic [1:0] PM_TRI = 2'h3;
   localparam logic [1:0] CLR_ZERO = 2'h0;
   localparam logic [1:0] CLR_MID = 2'h1;
   localparam logic [1:0] CLR_FULL = 2'h2;
   localparam logic [1:0] CLR_NOP = 2'h3;
   localparam logic [15:0] CODE_ZERO = 16'h0000;
   localparam logic [15:0] CODE_MID = 16'h8000;
   localparam logic [15:0] CODE_FULL = 16'hffff;
   localparam logic [15:0] RST_CODE = 16'h0000;
   localparam logic [7:0] RST_PM = 8'h00;
   localparam logic [3:0] RST_MASK = 4'h0;
   localparam logic [1:0] RST_CLR_SEL = 2'h0;
   localparam logic RST_FLAG = 1'b0;

   typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_DONE, FR_ABORT} qdc_frame_t;

   function automatic logic [15:0] clear_code(input logic [1:0] sel);
      logic [15:0] c;
      c = CODE_ZERO;
      if (sel == CLR_MID) begin
         c = CODE_MID;
      end else if (sel == CLR_FULL) begin
         c = CODE_FULL;
      end
      return c;
   endfunction

   function automatic logic addr_hit(input logic [3:0] a, input int ch);
      return (a == ADDR_ALL) || (a == 4'(ch));
   endfunction
endpackage

// File: hw/qdc_sync.sv
// two-flop pin synchronisers with edge detection on the settled level
module qdc_sync (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [qdc_pkg::PIN_W-1:0] pin_async,
   output logic [qdc_pkg::PIN_W-1:0] level_q,
   output logic [qdc_pkg::PIN_W-1:0] rise,
   output logic [qdc_pkg::PIN_W-1:0] fall
);
   import qdc_pkg::*;
   logic [PIN_W-1:0] meta_q;
   logic [PIN_W-1:0] last_q;

   // meta_q feeds level_q only; edges come from the settled stages
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         meta_q <= PIN_IDLE;
         level_q <= PIN_IDLE;
         last_q <= PIN_IDLE;
      end else begin
         meta_q <= pin_async;
         level_q <= meta_q;
         last_q <= level_q;
      end
   end

   assign rise = level_q & ~last_q;
   assign fall = ~level_q & last_q;
endmodule

// File: hw/qdc_chan.sv
// one channel: input register and converter register
module qdc_chan (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wr_en,
   input wire logic upd_en,
   input wire logic clr_en,
   input wire logic [qdc_pkg::CODE_W-1:0] wr_data,
   input wire logic [qdc_pkg::CODE_W-1:0] clr_data,
   output logic [qdc_pkg::CODE_W-1:0] conv_q
);
   import qdc_pkg::*;
   logic [CODE_W-1:0] input_q;

   // clear outranks anything else in the same cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         input_q <= RST_CODE;
      end else if (clr_en) begin
         input_q <= clr_data; // [R8]
      end else if (wr_en) begin
         input_q <= wr_data;
      end
   end

   // a write and an update together pass the new data straight through
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         conv_q <= RST_CODE;
      end else if (clr_en) begin
         conv_q <= clr_data; // [R8]
      end else if (upd_en) begin
         conv_q <= wr_en ? wr_data : input_q;
      end
   end
endmodule

// File: bench/qdc_host.sv
// host model that drives the three-wire serial link of the converter control
module qdc_host (
   input wire logic clk,
   output logic sclk,
   output logic frame_sel_n,
   output logic serial_data_in
);
   timeunit 1ns;
   timeprecision 100ps;

   // the link clock stands still high outside frames
   initial begin
      sclk = 1'b1;
      frame_sel_n = 1'b1;
      serial_data_in = 1'b1;
   end

   // sends nbits of w, msb first; fewer than 32 closes the frame early
   task automatic send(input logic [31:0] w, input int nbits);
      @(posedge clk);
      #1 frame_sel_n = 1'b0;
      // leave a full link period so the first falling edge is not lost
      #160;
      for (int i = 0; i < nbits; i++) begin
         serial_data_in = w[31-i];
         #80 sclk = 1'b0;
         #80 sclk = 1'b1;
      end
      #160 frame_sel_n = 1'b1;
      // released line shows the inverse, never a stale copy of the last bit
      serial_data_in = ~serial_data_in;
      #160;
   endtask
endmodule

// File: bench/quad_dac_command_control_test.sv
// self-checking bench for the quad converter command control
`define CHK(a, e) begin \
   num_checks++; \
   if ((a) !== (e)) begin \
      miscompares++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); \
   end \
end
module quad_dac_command_control_test;
   timeunit 1ns;
   timeprecision 100ps;
   import qdc_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic load_strobe_n = 1'b1;
   logic async_clear_n = 1'b1;
   logic sclk, frame_sel_n, serial_data_in;
   logic [63:0] conv_code;
   logic [7:0] power_mode;
   logic chain_enable, vref_on, clear_mode, serial_data_out;
   logic [63:0] ex;
   int miscompares = 0;
   int num_checks = 0;

   always #5 clk = ~clk;

   qdc_host host_u (.clk(clk), .sclk(sclk), .frame_sel_n(frame_sel_n),
      .serial_data_in(serial_data_in));

   qdc_ctrl dut_u (.clk(clk), .reset_n(reset_n), .sclk(sclk), .frame_sel_n(frame_sel_n),
      .serial_data_in(serial_data_in), .load_strobe_n(load_strobe_n),
      .async_clear_n(async_clear_n), .conv_code(conv_code), .power_mode(power_mode),
      .chain_enable(chain_enable), .vref_on(vref_on), .clear_mode(clear_mode),
      .serial_data_out(serial_data_out));

   function automatic logic [15:0] ch(input int n);
      return conv_code[16*n +: 16];
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // nonzero don't-care nibble shows that the top bits are ignored
   task automatic frm(input logic [3:0] cmd, input logic [3:0] adr, input logic [19:0] low);
      host_u.send({4'ha, cmd, adr, low}, 32);
   endtask

   task automatic ld(input logic v);
      tick(1);
      load_strobe_n = v;
   endtask

   task automatic clr(input logic v);
      tick(1);
      async_clear_n = v;
   endtask

   task automatic t_reset;
      `CHK(conv_code, 64'h0)
      `CHK(power_mode, 8'h00)
      `CHK({chain_enable, vref_on, clear_mode, serial_data_out}, 4'h0)
      $display("test reset done");
   endtask

   task automatic t_chain;
      frm(CMD_CHAIN_REF, 4'h5, 20'h00002);
      `CHK({chain_enable, vref_on}, 2'h2)
      // chain on by the last rising clock: the first bit sent (a one) shows as overflow
      `CHK(serial_data_out, 1'b1)
      frm(CMD_CHAIN_REF, 4'h0, 20'h00001);
      `CHK({chain_enable, vref_on}, 2'h1)
      `CHK(serial_data_out, 1'b0)
      $display("test chain done");
   endtask

   task automatic t_sync_load;
      ld(1'b0);
      frm(CMD_WR_IN, 4'h2, {16'h1234, 4'h0});
      `CHK(ch(2), 16'h1234)
      `CHK(ch(0), 16'h0000)
      ld(1'b1);
      $display("test sync load done");
   endtask

   task automatic t_async_load;
      frm(CMD_WR_IN, 4'h1, {16'habcd, 4'h0});
      `CHK(ch(1), 16'h0000)
      ld(1'b0);
      tick(6);
      `CHK(ch(1), 16'habcd)
      `CHK(ch(2), 16'h1234)
      ld(1'b1);
      $display("test async load done");
   endtask

   task automatic t_abort;
      ld(1'b0);
      host_u.send({4'h0, CMD_WR_IN, 4'h0, 16'hdead, 4'h0}, 31);
      `CHK(ch(0), 16'h0000)
      host_u.send({4'h0, CMD_CHAIN_REF, 4'h0, 20'h00002}, 20);
      `CHK({chain_enable, vref_on}, 2'h1)
      ld(1'b1);
      $display("test abort done");
   endtask

   task automatic t_mask;
      frm(CMD_MASK, 4'h7, 20'h00009);
      frm(CMD_WR_IN, 4'h0, {16'h0f0f, 4'h0});
      `CHK(ch(0), 16'h0f0f)
      frm(CMD_WR_IN, 4'h1, {16'h2222, 4'h0});
      `CHK(ch(1), 16'habcd)
      frm(CMD_MASK, 4'h0, 20'h00000);
      $display("test mask done");
   endtask

   task automatic t_soft_load;
      frm(CMD_WR_UPD_ALL, 4'h3, {16'h5555, 4'h0});
      `CHK(conv_code, {16'h5555, 16'h1234, 16'h2222, 16'h0f0f})
      // strobe high: the write stays in the input register until an update command
      frm(CMD_WR_IN, 4'h3, {16'h6666, 4'h0});
      `CHK(ch(3), 16'h5555)
      frm(CMD_UPD_N, ADDR_ALL, 20'h00000);
      `CHK(conv_code, {16'h6666, 16'h1234, 16'h2222, 16'h0f0f})
      $display("test software load done");
   endtask

   task automatic t_power;
      for (int m = 1; m < 4; m++) begin
         frm(CMD_POWER, 4'h0, {10'h0, 2'(m), 4'h0, 4'h5});
         `CHK(power_mode, {2'b00, 2'(m), 2'b00, 2'(m)})
      end
      // strobe high: waking must keep the held converter value, not the new input
      frm(CMD_WR_IN, 4'h0, {16'h7777, 4'h0});
      frm(CMD_POWER, 4'h0, {10'h0, PM_NORMAL, 4'h0, 4'hf});
      `CHK(power_mode, 8'h00)
      `CHK(ch(0), 16'h0f0f)
      $display("test power done");
   endtask

   task automatic t_clear;
      logic [15:0] tbl [4];
      tbl = '{16'h0000, 16'h8000, 16'hffff, 16'h0000};
      ex = conv_code;
      for (int k = 0; k < 4; k++) begin
         // first pass runs on the reset selection
         if (k > 0) begin
            frm(CMD_CLR_SEL, 4'h0, {18'h0, 2'(k)});
         end
         `CHK(clear_mode, 1'b0)
         clr(1'b0);
         tick(6);
         if (k != 3) begin
            ex = {4{tbl[k]}};
         end
         `CHK(conv_code, ex)
         `CHK(clear_mode, 1'(k != 3))
         // pin still low: only its falling edge may clear again
         frm(CMD_WR_UPD_N, 4'h1, {16'h3333, 4'h0});
         ex[31:16] = 16'h3333;
         `CHK(clear_mode, 1'b0)
         `CHK(conv_code, ex)
         clr(1'b1);
      end
      ld(1'b0);
      tick(6);
      `CHK(conv_code, ex)
      ld(1'b1);
      $display("test clear done");
   endtask

   task automatic t_clear_abort;
      frm(CMD_CLR_SEL, 4'h0, 20'h00001);
      ld(1'b0);
      fork
         host_u.send({4'h0, CMD_WR_IN, 4'h2, 16'h9999, 4'h0}, 32);
         begin
            tick(200);
            async_clear_n = 1'b0;
         end
      join
      tick(6);
      `CHK(conv_code, {4{16'h8000}})
      `CHK(clear_mode, 1'b1)
      clr(1'b1);
      ld(1'b1);
      $display("test clear abort done");
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // all frames together take well under half of this span
   initial begin
      #500000;
      miscompares++;
      complete_run;
   end

   initial begin
      repeat (3) @(posedge clk);
      #1 reset_n = 1'b1;
      tick(4);
      t_reset;
      t_chain;
      t_sync_load;
      t_async_load;
      t_abort;
      t_mask;
      t_soft_load;
      t_power;
      t_clear;
      t_clear_abort;
      complete_run;
   end
endmodule
